// file: logic/av_slave.sv
// avalon-mm slave handshake with one wait cycle
`timescale 1ns/1ns
module av_slave (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] rdata_in,
   output logic             waitrequest,
   output logic [31:0]      readdata,
   output logic             acc_wr
);
   typedef struct packed {
      logic        wait_r;
      logic [31:0] rdata_r;
   } av_s;

   av_s q_r;
   av_s q_nxt;

   // drop waitrequest for one cycle after a request is seen
   always_comb begin
      q_nxt = q_r;
      if ((read || write) && q_r.wait_r) begin
         q_nxt.wait_r  = 1'b0;
         q_nxt.rdata_r = read ? rdata_in : 32'h0000_0000;
      end else begin
         q_nxt.wait_r = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q_r <= '{wait_r: 1'b1, rdata_r: 32'h0000_0000};
      end else begin
         q_r <= q_nxt;
      end
   end

   assign waitrequest = q_r.wait_r;
   assign readdata    = q_r.rdata_r;
   assign acc_wr      = write && !q_r.wait_r; // write lands on the handshake edge
endmodule // av_slave

// file: logic/block_write_pkg.sv
// types shared by the validated block write port
package block_write_pkg;

   // one-hot transfer sequencer states
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_COLLECT = 4'h2,
      ST_CHECK   = 4'h4,
      ST_COMMIT  = 4'h8
   } state_e;

   // verdict of the last transfer
   typedef enum logic [3:0] {
      RSN_NONE    = 4'h0,
      RSN_PENDANT = 4'h1,
      RSN_NOADDR  = 4'h2,
      RSN_RDONLY  = 4'h3,
      RSN_TOOMANY = 4'h4,
      RSN_MOD3    = 4'h5,
      RSN_LIMIT   = 4'h6,
      RSN_PARCNT  = 4'h7,
      RSN_FORMAT  = 4'h8
   } reason_e;

   // internal address regions
   typedef enum logic [1:0] {
      RG_NONE = 2'h0,
      RG_POS  = 2'h1,
      RG_PAR  = 2'h2,
      RG_RO   = 2'h3
   } region_e;

endpackage

// file: logic/block_write_regs.svh
// constants for the validated block write port
`ifndef BLOCK_WRITE_REGS_SVH
`define BLOCK_WRITE_REGS_SVH
// Summary of operation
// (R01) The host checks every operand of a block write and, if one is wrong, raises its operand_error_flag and does not send it.
// (R02) The host raises its operand_error_flag and drops the write if the word count is past 0080 hex or the unit number past 005F hex.
// (R03) The host raises its operand_error_flag if the unit lacks intelligent_block_write or reports a setting or unit error.
// (R04) The device raises equals only when it has taken the data, with the transfer finished by then, and writes nothing when it refuses.
// (R05) The device refuses a new write while an earlier transfer is still running.
// (R06) The device refuses a write whose start address is not in its address map.
// (R07) The device refuses a write whose start address is read-only.
// (R08) The device refuses a position write whose word count is not a multiple of three.
// (R09) The device refuses a parameter write whose word count is not two.
// (R10) The device refuses a position write that would run past entry 07CF hex.
// (R11) The device refuses a position write of more than 12 words.
// (R12) The device refuses host writes while the teaching pendant is in enabled or priority mode.
// (R13) Badly formatted or out-of-range position data sets bit 14 of the status word.
// (R14) A block write never changes status bits 6, 7 and 9.
// (R15) Every refusal check stands alone and any failing one stops the whole write, so no partial data is stored.

// ==========================================================================
// avalon register byte offsets
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_RESULT    8'h08
`define REG_RD_SEL    8'h0C
`define REG_RD_LO     8'h10
`define REG_RD_HI     8'h14

// ==========================================================================
// internal address map
`define POS_LAST      16'h07CF
`define PAR_BASE      16'h0800
`define PAR_LAST      16'h083F
`define RO_BASE       16'h0900
`define RO_LAST       16'h093F

// ==========================================================================
// word counts and field positions
`define POS_MAX_WORDS 8'h0C
`define PAR_WORDS     8'h02
`define ST_FMT_BIT    14
`define ST_WRITING    6
`define ST_WR_ERR     7
`define ST_RD_ERR     9
`define CTRL_PEND_EN  0
`define CTRL_PEND_PRI 1
`define RD_SEL_PAR    15
`define STATUS_RESET  16'h0000
`define CTRL_RESET    2'h0

`endif

// file: logic/validated_block_write_port.sv
// block write port with device-side data check and equals answer
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`include "block_write_regs.svh"
module validated_block_write_port #(
   parameter int MAX_WORDS = 12,
   parameter int POS_DEPTH = 2000,
   parameter int PAR_DEPTH = 64
) (
   input  wire logic                          clk,
   input  wire logic                          srst,
   input  wire logic [7:0]                    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic [31:0]                        avs_readdata,
   output logic                               avs_waitrequest,
   input  wire logic                          blk_start,
   input  wire logic [15:0]                   blk_addr,
   input  wire logic [7:0]                    blk_count,
   input  wire logic                          blk_word_valid,
   input  wire logic [15:0]                   blk_word,
   output logic                               blk_busy,
   output logic                               blk_done,
   output logic                               blk_equals,
   output logic                               blk_reject,
   output logic [15:0]                        status_word,
   output block_write_pkg::reason_e           blk_reason
);
   import block_write_pkg::*;

   typedef struct packed {
      state_e                       st;
      logic [15:0]                  addr;
      logic [7:0]                   count;
      region_e                      rg;
      logic [3:0]                   widx;
      logic [2:0]                   eidx;
      logic [MAX_WORDS-1:0][15:0]   stage;
      logic                         fmt_err;
      logic [1:0]                   ctrl;
      logic [15:0]                  status;
      reason_e                      reason;
      logic [15:0]                  rd_sel;
      logic                         busy;
      logic                         done;
      logic                         equals;
      logic                         reject;
   } core_s;

   core_s        q_r;
   core_s        q_nxt;
   logic         acc_wr;
   logic [31:0]  rd_val;
   logic         fmt_bad;
   logic [7:0]   ent;
   logic [3:0]   ebase;
   logic         pos_we;
   logic         par_we;
   logic [47:0]  pos_rdata;
   logic [31:0]  par_rdata;

   // ==========================================================================
   // helpers

   function automatic region_e region_of(input logic [15:0] a);
      if (a <= `POS_LAST)
         return RG_POS;
      else if (a >= `PAR_BASE && a <= `PAR_LAST)
         return RG_PAR;
      else if (a >= `RO_BASE && a <= `RO_LAST)
         return RG_RO;
      else
         return RG_NONE;
   endfunction

   function automatic logic [7:0] div3(input logic [7:0] w);
      return 8'(w / 8'h03);
   endfunction

   // position high word must have a top byte of all zeros or all ones
   function automatic logic fmt_ok(input logic [15:0] hi);
      return (hi[15:8] == 8'h00) || (hi[15:8] == 8'hFF);
   endfunction

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // each check stands alone; first failing one names the refusal
   function automatic reason_e verdict(input logic [15:0] a, input logic [7:0] w,
                                       input logic [1:0] pend);
      region_e     rg;
      logic [16:0] last;
      rg   = region_of(a);
      last = {1'b0, a} + {9'h000, div3(w)} - 17'h00001;
      if (|pend)
         return RSN_PENDANT; // R12
      else if (rg == RG_NONE)
         return RSN_NOADDR; // R06
      else if (rg == RG_RO)
         return RSN_RDONLY; // R07
      else if (rg == RG_POS && w > `POS_MAX_WORDS)
         return RSN_TOOMANY; // R11
      else if (rg == RG_POS && (w % 8'h03) != 8'h00)
         return RSN_MOD3; // R08
      else if (rg == RG_POS && w != 8'h00 && last > {1'b0, `POS_LAST})
         return RSN_LIMIT; // R10
      else if (rg == RG_PAR && w != `PAR_WORDS)
         return RSN_PARCNT; // R09
      else
         return RSN_NONE; // R15
   endfunction

   // ==========================================================================
   // register bus

   av_slave u_av (
      .clk         (clk),
      .srst        (srst),
      .read        (avs_read),
      .write       (avs_write),
      .rdata_in    (rd_val),
      .waitrequest (avs_waitrequest),
      .readdata    (avs_readdata),
      .acc_wr      (acc_wr)
   );

   // read mux; unmapped offsets read zero
   always_comb begin
      unique case (avs_address)
         `REG_CTRL:   rd_val = {30'h0000_0000, q_r.ctrl};
         `REG_STATUS: rd_val = {16'h0000, q_r.status};
         `REG_RESULT: rd_val = {22'h00_0000, q_r.busy, q_r.equals, 4'h0, q_r.reason};
         `REG_RD_SEL: rd_val = {16'h0000, q_r.rd_sel};
         `REG_RD_LO:  rd_val = q_r.rd_sel[`RD_SEL_PAR] ? par_rdata : pos_rdata[31:0];
         `REG_RD_HI:  rd_val = q_r.rd_sel[`RD_SEL_PAR] ? 32'h0000_0000
                                                       : {16'h0000, pos_rdata[47:32]};
         default:     rd_val = 32'h0000_0000;
      endcase
   end

   // ==========================================================================
   // storage

   assign ebase  = 4'({q_r.eidx, 1'b0} + {1'b0, q_r.eidx});
   assign pos_we = (q_r.st == ST_COMMIT) && (q_r.rg == RG_POS) && !q_r.fmt_err
                   && ({5'h00, q_r.eidx} < ent); // R15
   assign par_we = (q_r.st == ST_COMMIT) && (q_r.rg == RG_PAR);

   word_store #(.W(48), .DEPTH(POS_DEPTH), .AW(11)) u_pos (
      .clk   (clk),
      .srst  (srst),
      .we    (pos_we),
      .waddr (11'(q_r.addr[10:0] + {8'h00, q_r.eidx})),
      .wdata ({q_r.stage[ebase + 4'h2], q_r.stage[ebase + 4'h1], q_r.stage[ebase]}),
      .raddr (q_r.rd_sel[10:0]),
      .rdata (pos_rdata)
   );

   word_store #(.W(32), .DEPTH(PAR_DEPTH), .AW(6)) u_par (
      .clk   (clk),
      .srst  (srst),
      .we    (par_we),
      .waddr (q_r.addr[5:0]),
      .wdata ({q_r.stage[1], q_r.stage[0]}),
      .raddr (q_r.rd_sel[5:0]),
      .rdata (par_rdata)
   );

   // ==========================================================================
   // transfer sequencer and register writes

   always_comb begin
      reason_e     rsn;
      logic [31:0] m;
      rsn      = RSN_NONE;
      m        = be_mask(avs_byteenable);
      q_nxt    = q_r;
      ent      = div3(q_r.count);
      fmt_bad  = 1'b0;
      q_nxt.done   = 1'b0;
      q_nxt.reject = 1'b0;
      // software writes first so a hardware set in the same cycle wins
      if (acc_wr) begin
         unique case (avs_address)
            `REG_CTRL: if (m[0]) q_nxt.ctrl = avs_writedata[1:0];
            `REG_STATUS: begin
               if (m[8] && avs_writedata[`ST_FMT_BIT])
                  q_nxt.status[`ST_FMT_BIT] = 1'b0;
               // save/read engine bits are loaded only from software
               if (m[0]) begin // R14
                  q_nxt.status[`ST_WRITING] = avs_writedata[`ST_WRITING];
                  q_nxt.status[`ST_WR_ERR]  = avs_writedata[`ST_WR_ERR];
               end
               if (m[8]) q_nxt.status[`ST_RD_ERR] = avs_writedata[`ST_RD_ERR];
            end
            `REG_RD_SEL: q_nxt.rd_sel = (q_r.rd_sel & ~m[15:0]) | (avs_writedata[15:0] & m[15:0]);
            default: ;
         endcase
      end
      unique case (q_r.st)
         ST_IDLE: begin
            if (blk_start) begin
               rsn           = verdict(blk_addr, blk_count, q_r.ctrl);
               q_nxt.addr    = blk_addr;
               q_nxt.count   = blk_count;
               q_nxt.rg      = region_of(blk_addr);
               q_nxt.widx    = 4'h0;
               q_nxt.eidx    = 3'h0;
               q_nxt.fmt_err = 1'b0;
               q_nxt.equals  = 1'b0;
               if (rsn != RSN_NONE) begin
                  q_nxt.done   = 1'b1; // R04
                  q_nxt.reason = rsn;
               end else begin
                  q_nxt.busy = 1'b1;
                  q_nxt.st   = (blk_count == 8'h00) ? ST_CHECK : ST_COLLECT;
               end
            end
         end
         ST_COLLECT: begin
            if (blk_word_valid) begin
               q_nxt.stage[q_r.widx] = blk_word;
               q_nxt.widx            = 4'(q_r.widx + 4'h1);
               if (4'(q_r.widx + 4'h1) == q_r.count[3:0])
                  q_nxt.st = ST_CHECK;
            end
         end
         ST_CHECK: begin
            for (int i = 0; i < MAX_WORDS / 3; i++) begin
               if (q_r.rg == RG_POS && 8'(i) < ent && !fmt_ok(q_r.stage[3 * i + 2]))
                  fmt_bad = 1'b1;
            end
            q_nxt.fmt_err = fmt_bad;
            if (fmt_bad)
               q_nxt.status[`ST_FMT_BIT] = 1'b1; // R13
            q_nxt.st = ST_COMMIT;
         end
         ST_COMMIT: begin
            if (pos_we && ({5'h00, q_r.eidx} + 8'h01) < ent) begin
               q_nxt.eidx = 3'(q_r.eidx + 3'h1);
            end else begin
               // the last entry is written on the same edge that raises equals; after a format error nothing is written
               q_nxt.st     = ST_IDLE;
               q_nxt.busy   = 1'b0;
               q_nxt.done   = 1'b1;
               q_nxt.equals = 1'b1; // R04
               q_nxt.reason = q_r.fmt_err ? RSN_FORMAT : RSN_NONE;
            end
         end
      endcase
      // a start during a running transfer is dropped untouched
      if (blk_start && q_r.st != ST_IDLE)
         q_nxt.reject = 1'b1; // R05
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q_r        <= '0;
         q_r.st     <= ST_IDLE;
         q_r.rg     <= RG_NONE;
         q_r.reason <= RSN_NONE;
         q_r.ctrl   <= `CTRL_RESET;
         q_r.status <= `STATUS_RESET;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign blk_busy    = q_r.busy;
   assign blk_done    = q_r.done;
   assign blk_equals  = q_r.equals;
   assign blk_reject  = q_r.reject;
   assign status_word = q_r.status;
   assign blk_reason  = q_r.reason;

   // ==========================================================================
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   equals_with_done_a: // R04
   assert property ($rose(blk_equals) |-> blk_done && !blk_busy)
      else $error("equals rose without a finished transfer");

   busy_refused_a: // R05
   assert property (blk_start && blk_busy |=> blk_reject ##0 $stable(q_r.addr))
      else $error("start during a transfer was not refused");

   no_address_a: // R06
   assert property (blk_start && !blk_busy && q_r.ctrl == 2'h0
                    && region_of(blk_addr) == RG_NONE |=> blk_done && !blk_equals && !blk_busy)
      else $error("write to missing address not refused");

   read_only_a: // R07
   assert property (blk_start && !blk_busy && q_r.ctrl == 2'h0
                    && region_of(blk_addr) == RG_RO |=> blk_done && !blk_equals && !blk_busy)
      else $error("write to read-only address not refused");

   pos_mod3_a: // R08
   assert property (blk_start && !blk_busy && q_r.ctrl == 2'h0 && region_of(blk_addr) == RG_POS
                    && (blk_count % 8'h03) != 8'h00 |=> blk_done && !blk_equals)
      else $error("position count not multiple of three accepted");

   par_count_a: // R09
   assert property (blk_start && !blk_busy && q_r.ctrl == 2'h0 && region_of(blk_addr) == RG_PAR
                    && blk_count != 8'h02 |=> blk_done && !blk_equals && blk_reason == RSN_PARCNT)
      else $error("parameter count other than two accepted");

   pos_limit_a: // R10
   assert property (blk_start && !blk_busy && q_r.ctrl == 2'h0 && region_of(blk_addr) == RG_POS
                    && blk_count <= 8'h0C && (blk_count % 8'h03) == 8'h00 && blk_count != 8'h00
                    && ({1'b0, blk_addr} + {9'h000, div3(blk_count)}) > 17'h007D0
                    |=> blk_done && !blk_equals)
      else $error("position write past last entry accepted");

   pos_too_many_a: // R11
   assert property (blk_start && !blk_busy && q_r.ctrl == 2'h0 && region_of(blk_addr) == RG_POS
                    && blk_count > 8'h0C |=> blk_done && !blk_equals && blk_reason == RSN_TOOMANY)
      else $error("position write over twelve words accepted");

   pendant_lock_a: // R12
   assert property (blk_start && !blk_busy && q_r.ctrl != 2'h0
                    |=> blk_done && !blk_equals && blk_reason == RSN_PENDANT)
      else $error("write accepted while pendant holds control");

   format_flag_a: // R13
   assert property (q_r.st == ST_CHECK && fmt_bad |=> status_word[14] ##1 blk_done)
      else $error("format error did not set status bit");

   status_keep_a: // R14
   assert property (!(acc_wr && avs_address == `REG_STATUS)
                    |=> $stable({status_word[9], status_word[7], status_word[6]}))
      else $error("status bits 6, 7 or 9 changed without software");

   no_partial_a: // R15
   assert property (q_r.st == ST_CHECK && fmt_bad |=> !pos_we [*2])
      else $error("data stored after a failed format check");
endmodule // validated_block_write_port

// file: logic/word_store.sv
// single-port-write, registered-read storage array
`timescale 1ns/1ns
module word_store #(
   parameter int W     = 48,
   parameter int DEPTH = 2000,
   parameter int AW    = 11
) (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic [W-1:0]       rdata
);
   typedef struct packed {
      logic [W-1:0] rdata_r;
   } rd_s;

   logic [W-1:0] mem [DEPTH];
   rd_s          q_r;
   rd_s          q_nxt;

   // array holds no reset: contents are undefined until first written
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_comb begin
      q_nxt         = q_r;
      q_nxt.rdata_r = mem[raddr];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign rdata = q_r.rdata_r;
endmodule // word_store

// file: sim/host_model.sv
// host controller model that issues block writes over the block link
`timescale 1ns/1ns
module host_model #(
   parameter bit UNIT_OK = 1'b1
) (
   input  wire logic        clk,
   output logic             blk_start,
   output logic [15:0]      blk_addr,
   output logic [7:0]       blk_count,
   output logic             blk_word_valid,
   output logic [15:0]      blk_word,
   input  wire logic        blk_busy,
   input  wire logic        blk_done,
   input  wire logic        blk_equals,
   input  wire logic        blk_reject,
   output logic             operand_error_flag
);
   // idle link at time zero
   initial begin
      blk_start = 1'b0;
      blk_addr = 16'h0000;
      blk_count = 8'h00;
      blk_word_valid = 1'b0;
      blk_word = 16'h0000;
      operand_error_flag = 1'b0;
   end

   // one block write; dbl repeats the start while the first one runs
   task automatic send(input logic [7:0] unit, input logic [15:0] a, input logic [7:0] n,
                       input logic [15:0] w [12], input bit dbl, output logic eq,
                       output logic rej);
      int i;
      int t;
      eq = 1'b0;
      rej = 1'b0;
      // operands are vetted before anything reaches the unit
      operand_error_flag = (n > 8'h80) || (unit > 8'h5F) || !UNIT_OK;
      if (operand_error_flag) return;
      @(posedge clk);
      blk_start <= 1'b1;
      blk_addr <= a;
      blk_count <= n;
      @(posedge clk);
      // released lines show the inverse so a stale value is never reused
      blk_start <= 1'b0;
      blk_addr <= ~a;
      blk_count <= ~n;
      @(posedge clk);
      if (blk_busy === 1'b1) begin
         if (dbl) begin
            blk_start <= 1'b1;
            @(posedge clk);
            blk_start <= 1'b0;
         end
         for (i = 0; i < n; i++) begin
            blk_word_valid <= 1'b1;
            blk_word <= w[i];
            @(posedge clk);
            rej |= (blk_reject === 1'b1);
         end
         blk_word_valid <= 1'b0;
         blk_word <= ~w[n-1];
      end
      t = 0;
      while (blk_done !== 1'b1 && t < 64) begin
         @(posedge clk);
         rej |= (blk_reject === 1'b1);
         t++;
      end
      eq = blk_equals;
   endtask
endmodule // host_model

// file: sim/tb_top.sv
// self-checking bench for the validated block write port
`timescale 1ns/1ns
`include "block_write_regs.svh"
module tb_top;
   import block_write_pkg::*;
   logic clk, srst, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q, seed;
   logic [3:0] avs_byteenable;
   logic blk_start, blk_word_valid, blk_busy, blk_done, blk_equals, blk_reject, op_err, eq, rej;
   logic op_err_nu;
   logic [15:0] blk_addr, blk_word, status_word, a;
   logic [7:0] blk_count;
   reason_e blk_reason;
   logic [15:0] wv [12];
   logic [15:0] sv [12];
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [15:0] ca [6] = '{16'h0A00, 16'h0900, 16'h0010, 16'h0010, 16'h07CF, 16'h0800};
   logic [7:0] cc [6] = '{8'h03, 8'h02, 8'h0F, 8'h04, 8'h06, 8'h03};
   reason_e cr [6] = '{RSN_NOADDR, RSN_RDONLY, RSN_TOOMANY, RSN_MOD3, RSN_LIMIT, RSN_PARCNT};

   validated_block_write_port dut_u (.clk(clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .blk_start(blk_start), .blk_addr(blk_addr),
      .blk_count(blk_count), .blk_word_valid(blk_word_valid), .blk_word(blk_word),
      .blk_busy(blk_busy), .blk_done(blk_done), .blk_equals(blk_equals),
      .blk_reject(blk_reject), .status_word(status_word), .blk_reason(blk_reason));
   host_model host_u (.clk(clk), .blk_start(blk_start), .blk_addr(blk_addr),
      .blk_count(blk_count), .blk_word_valid(blk_word_valid), .blk_word(blk_word),
      .blk_busy(blk_busy), .blk_done(blk_done), .blk_equals(blk_equals),
      .blk_reject(blk_reject), .operand_error_flag(op_err));
   // a host facing a unit without block write support; its link pins stay unused
   host_model #(.UNIT_OK(1'b0)) unsup_u (.clk(clk), .blk_start(), .blk_addr(), .blk_count(),
      .blk_word_valid(), .blk_word(), .blk_busy(blk_busy), .blk_done(blk_done),
      .blk_equals(blk_equals), .blk_reject(blk_reject), .operand_error_flag(op_err_nu));

   // 20 MHz clock and a cycle ceiling against hangs
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("errors %0d compares %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // xorshift draw, fixed seed
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // avalon cycle: request held until waitrequest is seen low
   task automatic av(input logic wr, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
      @(posedge clk);
      avs_address <= ad;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      // no local limit: only the bench ceiling ends a stuck wait
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // random words; third word of an entry gets a legal or illegal top byte
   task automatic fill(input bit bad);
      for (int i = 0; i < 12; i++) begin
         wv[i] = 16'(rnd());
         if (i % 3 == 2) wv[i][15:8] = bad ? 8'h12 : (seed[20] ? 8'hFF : 8'h00);
      end
   endtask
   task automatic put(input logic [15:0] ad, input logic [7:0] n, input bit dbl);
      host_u.send(8'h00, ad, n, wv, dbl, eq, rej);
   endtask
   task automatic chk_pos(input logic [15:0] ad, input int k);
      for (int j = 0; j < k; j++) begin
         av(1'b1, `REG_RD_SEL, {16'h0, ad + 16'(j)}, q);
         av(1'b0, `REG_RD_LO, 32'h0, q);
         chk(q, {wv[3*j+1], wv[3*j]});
         av(1'b0, `REG_RD_HI, 32'h0, q);
         chk({16'h0, q[15:0]}, {16'h0, wv[3*j+2]});
      end
   endtask

   initial begin
      srst = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      seed = 32'd21486;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({16'h0, status_word}, {16'h0, `STATUS_RESET});
      chk({28'h0, blk_reason}, {28'h0, RSN_NONE});
      av(1'b0, 8'h20, 32'h0, q);
      chk(q, 32'h0);
      av(1'b1, `REG_STATUS, 32'h0000_02C0, q);
      // accepted position writes, one with a second start while busy
      for (int k = 0; k < 4; k++) begin
         a = (k == 0) ? 16'h0010 : 16'h0100 + 16'(rnd() % 32'h600);
         fill(1'b0);
         if (k == 0) sv = wv;
         put(a, 8'(3 * (k + 1)), k == 2);
         chk_flag(eq, 1'b1);
         chk_flag(op_err, 1'b0);
         chk_flag(rej, k == 2);
         chk({28'h0, blk_reason}, {28'h0, RSN_NONE});
         chk_pos(a, k + 1);
      end
      fill(1'b0);
      put(16'h07CF, 8'h03, 1'b0);
      chk_flag(eq, 1'b1);
      chk_pos(16'h07CF, 1);
      a = 16'h0800 + 16'(rnd() % 32'h40);
      fill(1'b0);
      put(a, 8'h02, 1'b0);
      chk_flag(eq, 1'b1);
      av(1'b1, `REG_RD_SEL, {16'h0, 16'h8000 | (a - 16'h0800)}, q);
      av(1'b0, `REG_RD_LO, 32'h0, q);
      chk(q, {wv[1], wv[0]});
      // bad third word: flagged, nothing stored
      fill(1'b1);
      put(16'h0010, 8'h03, 1'b0);
      chk_flag(eq, 1'b1);
      chk({28'h0, blk_reason}, {28'h0, RSN_FORMAT});
      av(1'b0, `REG_RESULT, 32'h0, q);
      chk(q, 32'h0000_0108);
      chk_flag(status_word[`ST_FMT_BIT], 1'b1);
      chk({16'h0, status_word & 16'h02C0}, 32'h0000_02C0);
      wv = sv;
      chk_pos(16'h0010, 1);
      av(1'b1, `REG_STATUS, 32'h0000_42C0, q);
      // the clear lands on the handshake edge; look one cycle later
      @(posedge clk);
      chk({16'h0, status_word}, 32'h0000_02C0);
      // every refusal code but the pendant one, entry 0x0010 must survive
      for (int i = 0; i < 6; i++) begin
         fill(1'b0);
         put(ca[i], cc[i], 1'b0);
         chk_flag(eq, 1'b0);
         chk({28'h0, blk_reason}, {28'h0, cr[i]});
      end
      wv = sv;
      chk_pos(16'h0010, 1);
      // pendant enabled, then priority
      for (int m = 1; m < 3; m++) begin
         av(1'b1, `REG_CTRL, 32'(m), q);
         fill(1'b0);
         put(16'h0010, 8'h03, 1'b0);
         chk_flag(eq, 1'b0);
         chk({28'h0, blk_reason}, {28'h0, RSN_PENDANT});
      end
      av(1'b1, `REG_CTRL, 32'h0, q);
      host_u.send(8'h00, 16'h0010, 8'h81, wv, 1'b0, eq, rej);
      chk_flag(op_err, 1'b1);
      host_u.send(8'h60, 16'h0010, 8'h03, wv, 1'b0, eq, rej);
      chk_flag(op_err, 1'b1);
      unsup_u.send(8'h00, 16'h0010, 8'h03, wv, 1'b0, eq, rej);
      chk_flag(op_err_nu, 1'b1);
      chk({16'h0, status_word}, 32'h0000_02C0);
      stop_test();
   end
endmodule // tb_top
